// ### verification/irq_vector_sfr_lowpower_test.sv
// Self-checking bench for vectoring, registers and sleep gating
`timescale 1ns/1ns
`default_nettype none
module irq_vector_sfr_lowpower_test;
  logic pclk = 0, presetn = 0, vcc_por_n = 0, psel = 0, penable = 0;
  logic pwrite = 0, rst_nmi_pin = 1, pin_is_reset = 0, gie = 0, take_en = 0;
  logic wdog_interval_mode = 0, flash_violation_flag = 0;
  logic timer_cmp0_flag = 0, timer_other_flags = 0, converter_done_flag = 0;
  logic [7:0] paddr = 0, port1_pin_flags = 0, port2_pin_flags = 0;
  logic [31:0] pwdata = 0, prdata, rd_q;
  logic [1:0] ack_wait = 0;
  logic [6:0] pls = 0;
  logic pready, pslverr, irq_ack, irq_return, irq_req, err_q;
  logic handler_valid, handler_is_reset, cpu_en, mclk_en, peripheral_sub_clock_en;
  logic aclk_en, bias_en, xtal_en;
  logic async_rx_module_en, async_tx_module_en, sync_mode_module_en;
  logic [15:0] irq_vec_addr, handler_addr, taken_vec;
  logic [3:0] lp_code [8] = '{4'h0, 4'h6, 4'h1, 4'h2, 4'ha, 4'h3, 4'h4,
                              4'h5};
  logic [5:0] lp_exp [8] = '{6'h3f, 6'h3f, 6'h0f, 6'h0d, 6'h0f, 6'h07,
                             6'h05, 6'h00};
  int n_mismatch = 0, checked = 0, cyc = 0;
  always #20 pclk = ~pclk;
  ivs_ctrl #(.AW(8)) u_ivs_ctrl (
    .pclk, .presetn, .vcc_por_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rst_nmi_pin, .pin_is_reset,
    .wdog_overflow(pls[4]), .wdog_interval_mode, .osc_fault_det(pls[6]),
    .security_key_violation(pls[5]), .flash_violation_flag,
    .timer_cmp0_flag, .timer_other_flags, .serial_rx_set(pls[0]),
    .serial_rx_clr(pls[1]), .serial_tx_set(pls[2]), .serial_tx_clr(pls[3]),
    .converter_done_flag, .port1_pin_flags, .port2_pin_flags, .gie,
    .irq_ack, .irq_return, .irq_req, .irq_vec_addr, .handler_addr,
    .handler_valid, .handler_is_reset, .async_rx_module_en,
    .async_tx_module_en, .sync_mode_module_en, .cpu_en, .mclk_en,
    .peripheral_sub_clock_en, .aclk_en, .bias_en, .xtal_en
  );
  ivs_cpu_model u_ivs_cpu_model (
    .pclk, .presetn, .take_en, .ack_wait, .irq_req, .irq_vec_addr,
    .handler_valid, .handler_is_reset, .irq_ack, .irq_return, .taken_vec
  );
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_q, exp);
  endtask
  // Alternates a prompt and a slow core; the handler word encodes its slot
  task take(input logic [15:0] v);
    int n;
    n = 0;
    take_en <= 1'b1;
    ack_wait <= ack_wait ^ 2'd3;
    @(posedge pclk);
    while (!(handler_valid === 1'b1 && handler_is_reset === 1'b0) && n < 200) begin
      n++;
      @(posedge pclk);
    end
    take_en <= 1'b0;
    chk(taken_vec, v);
    chk(handler_addr, 16'h8000 | v[4:1]);
    @(posedge pclk);
  endtask
  task pulse(input int b);
    pls[b] <= 1'b1;
    @(posedge pclk);
    pls[b] <= 1'b0;
    @(posedge pclk);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    vcc_por_n <= 1'b1;
    @(posedge pclk);
    #1;
    chk({handler_valid, handler_is_reset, handler_addr}, 18'h3f000);
    @(posedge pclk);
    chk({cpu_en, mclk_en, peripheral_sub_clock_en, aclk_en, bias_en, xtal_en}, 6'h3f);
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h0c, 32'h2);
    rdc(8'h14, 32'h0);
    wr(8'h00, 32'hff);
    rdc(8'h00, 32'h33);
    wr(8'h04, 32'hff);
    rdc(8'h04, 32'h3);
    wr(8'h14, 32'hff);
    rdc(8'h14, 32'h7);
    chk({async_rx_module_en, async_tx_module_en, sync_mode_module_en}, 3'h7);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h14, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(err_q, 1'b1);
    apb(1'b1, 8'h01, 32'hff);
    chk(err_q, 1'b1);
    rdc(8'h00, 32'h0);
    for (int p = 0; p < 16; p++) wr(8'h40 + 8'(4 * p), 32'h8000 | p);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      wr(8'h18, {28'h0, lp_code[i]});
      repeat (2) @(posedge pclk);
      chk({cpu_en, mclk_en, peripheral_sub_clock_en, aclk_en, bias_en, xtal_en}, lp_exp[i]);
    end
    gie <= 1'b1;
    port1_pin_flags <= 8'h01;
    take(16'hffe4);
    chk(cpu_en, 1'b1);
    port1_pin_flags <= 8'h00;
    repeat (8) @(posedge pclk);
    chk({cpu_en, aclk_en, xtal_en}, 3'h0);
    wr(8'h18, 32'h0);
    $display("test sleep done");
    timer_cmp0_flag <= 1'b1;
    port2_pin_flags <= 8'h80;
    take(16'hfff2);
    timer_cmp0_flag <= 1'b0;
    take(16'hffe6);
    port2_pin_flags <= 8'h00;
    timer_other_flags <= 1'b1;
    take(16'hfff0);
    timer_other_flags <= 1'b0;
    converter_done_flag <= 1'b1;
    take(16'hffea);
    converter_done_flag <= 1'b0;
    wr(8'h0c, 32'h0);
    wr(8'h04, 32'h3);
    pulse(0);
    take(16'hffee);
    pulse(1);
    pulse(2);
    take(16'hffec);
    pulse(3);
    rdc(8'h0c, 32'h0);
    wr(8'h04, 32'h0);
    $display("test vectors done");
    wr(8'h00, 32'h1);
    pulse(4);
    repeat (3) @(posedge pclk);
    chk(irq_req, 1'b0);
    rdc(8'h08, 32'h1);
    vcc_por_n <= 1'b0;
    @(posedge pclk);
    vcc_por_n <= 1'b1;
    @(posedge pclk);
    rdc(8'h08, 32'h0);
    pulse(5);
    rdc(8'h08, 32'h1);
    wdog_interval_mode <= 1'b1;
    take(16'hfff4);
    wr(8'h08, 32'h0);
    wdog_interval_mode <= 1'b0;
    gie <= 1'b0;
    wr(8'h00, 32'h32);
    rst_nmi_pin <= 1'b0;
    take(16'hfffc);
    rst_nmi_pin <= 1'b1;
    rdc(8'h08, 32'h10);
    wr(8'h08, 32'h0);
    pulse(6);
    take(16'hfffc);
    rdc(8'h08, 32'h2);
    wr(8'h08, 32'h0);
    flash_violation_flag <= 1'b1;
    take(16'hfffc);
    flash_violation_flag <= 1'b0;
    wr(8'h00, 32'h0);
    pulse(4);
    pin_is_reset <= 1'b1;
    rst_nmi_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    rst_nmi_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    pin_is_reset <= 1'b0;
    rdc(8'h08, 32'h0);
    $display("test sources done");
    end_of_test();
  end
endmodule
`default_nettype wire

// ### verification/ivs_cpu_model.sv
// Behavioural CPU core: takes offered vectors and returns from handlers
`timescale 1ns/1ns
`default_nettype none
module ivs_cpu_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        take_en,
  input  wire logic [1:0]  ack_wait,
  input  wire logic        irq_req,
  input  wire logic [15:0] irq_vec_addr,
  input  wire logic        handler_valid,
  input  wire logic        handler_is_reset,
  output logic             irq_ack,
  output logic             irq_return,
  output logic [15:0]      taken_vec
);
  logic [1:0] wait_q;
  logic [1:0] svc_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      wait_q <= 2'd0;
      svc_q <= 2'd0;
      taken_vec <= 16'h0000;
    end else begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      if (!irq_req)
        wait_q <= 2'd0;
      else if (wait_q != 2'd3)
        wait_q <= wait_q + 2'd1;
      // Slow takes hold off until the request has waited ack_wait cycles
      if (irq_req && take_en && svc_q == 2'd0 && !irq_ack && wait_q >= ack_wait)
        irq_ack <= 1'b1;
      if (irq_req && irq_ack)
        taken_vec <= irq_vec_addr;
      if (handler_valid && !handler_is_reset)
        svc_q <= 2'd3;
      else if (svc_q != 2'd0) begin
        svc_q <= svc_q - 2'd1;
        irq_return <= (svc_q == 2'd1);
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/ivs_ctrl_asserts.sv
// Concurrent checks on vectoring, bus answer and clock gating ports
`timescale 1ns/1ns
`default_nettype none
module ivs_ctrl_asserts #(
  parameter AW = 8
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic [AW-1:0] paddr,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          gie,
  input wire logic          irq_ack,
  input wire logic          irq_req,
  input wire logic [15:0]   irq_vec_addr,
  input wire logic          handler_valid,
  input wire logic          timer_cmp0_flag,
  input wire logic          timer_other_flags,
  input wire logic [7:0]    port1_pin_flags,
  input wire logic          cpu_en,
  input wire logic          mclk_en,
  input wire logic          peripheral_sub_clock_en,
  input wire logic          aclk_en,
  input wire logic          bias_en,
  input wire logic          xtal_en
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_take;
    irq_req && irq_ack;
  endsequence
  sequence s_fetch;
    handler_valid && !irq_req;
  endsequence
  property p_table;
    irq_req |-> irq_vec_addr[15:5] == 11'h7ff && !irq_vec_addr[0];
  endproperty
  a_table: assert property (p_table) else $error("vector off table");
  property p_take;
    s_take |=> s_fetch;
  endproperty
  a_take: assert property (p_take) else $error("no handler fetch");
  property p_nmi;
    !$past(gie) && irq_req |-> irq_vec_addr == 16'hfffc;
  endproperty
  a_nmi: assert property (p_nmi) else $error("maskable without gie");
  property p_prio;
    $past(gie && timer_cmp0_flag) && irq_req |-> irq_vec_addr >= 16'hfff2;
  endproperty
  a_prio: assert property (p_prio) else $error("lower vector first");
  property p_tmr;
    irq_req && irq_vec_addr == 16'hfff0 |-> $past(timer_other_flags);
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer vector no cause");
  property p_port1;
    irq_req && irq_vec_addr == 16'hffe4 |-> $past(|port1_pin_flags);
  endproperty
  a_port1: assert property (p_port1) else $error("port vector no cause");
  property p_run;
    cpu_en |-> mclk_en && peripheral_sub_clock_en && aclk_en && bias_en && xtal_en;
  endproperty
  a_run: assert property (p_run) else $error("clock off while running");
  property p_sub;
    !peripheral_sub_clock_en |-> !mclk_en && !cpu_en;
  endproperty
  a_sub: assert property (p_sub) else $error("main clock without sub");
  property p_deep;
    !xtal_en |-> !aclk_en && !bias_en && !peripheral_sub_clock_en && !cpu_en;
  endproperty
  a_deep: assert property (p_deep) else $error("deep sleep leak");
  property p_wake;
    irq_req |-> ##[0:2] cpu_en;
  endproperty
  a_wake: assert property (p_wake) else $error("request did not wake");
  property p_err;
    psel && !penable && paddr[1:0] != 2'b00 |=> pready && pslverr;
  endproperty
  a_err: assert property (p_err) else $error("misaligned accepted");
endmodule
bind ivs_ctrl ivs_ctrl_asserts #(.AW(AW)) u_ivs_ctrl_asserts (
  .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .gie,
  .irq_ack, .irq_req, .irq_vec_addr, .handler_valid, .timer_cmp0_flag,
  .timer_other_flags, .port1_pin_flags, .cpu_en, .mclk_en, .peripheral_sub_clock_en,
  .aclk_en, .bias_en, .xtal_en
);
`default_nettype wire

// ### verilog/ivs_ctrl.v
// Interrupt vectoring, special-function registers and sleep-level gating
`timescale 1ns/1ns
`default_nettype none
`include "ivs_map.vh"
module ivs_ctrl #(
  parameter AW = 8
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          vcc_por_n,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  input  wire          rst_nmi_pin,
  input  wire          pin_is_reset,
  input  wire          wdog_overflow,
  input  wire          wdog_interval_mode,
  input  wire          security_key_violation,
  input  wire          osc_fault_det,
  input  wire          flash_violation_flag,
  input  wire          timer_cmp0_flag,
  input  wire          timer_other_flags,
  input  wire          serial_rx_set,
  input  wire          serial_rx_clr,
  input  wire          serial_tx_set,
  input  wire          serial_tx_clr,
  input  wire          converter_done_flag,
  input  wire [7:0]    port1_pin_flags,
  input  wire [7:0]    port2_pin_flags,
  input  wire          gie,
  input  wire          irq_ack,
  input  wire          irq_return,
  output reg           irq_req,
  output reg  [15:0]   irq_vec_addr,
  output wire [15:0]   handler_addr,
  output reg           handler_valid,
  output reg           handler_is_reset,
  output reg           async_rx_module_en,
  output reg           async_tx_module_en,
  output reg           sync_mode_module_en,
  output reg           cpu_en,
  output reg           mclk_en,
  output reg           peripheral_sub_clock_en,
  output reg           aclk_en,
  output reg           bias_en,
  output reg           xtal_en
);
  localparam ST_BOOT = 2'b01;
  localparam ST_RUN  = 2'b10;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [3:0]  ie1_q;
  reg  [1:0]  ie2_q;
  reg         wdog_flag_q;
  reg         osc_flag_q;
  reg         nmi_flag_q;
  reg         srx_flag_q;
  reg         stx_flag_q;
  reg  [2:0]  mode_q;
  reg         dco_used_q;
  reg         awake_q;
  reg  [3:0]  pri_q;
  reg         pin_s1_q;
  reg         pin_s2_q;
  reg         pin_s3_q;
  reg  [15:0] pend;
  reg  [3:0]  top_pri;
  reg         any_pend;
  reg  [31:0] rd_val;
  reg         addr_ok;
  reg  [2:0]  eff_mode;
  integer     k;

  wire        setup   = psel & ~penable;
  // Refused transfers must not touch a register
  wire        wr_acc  = psel & penable & pwrite & pready & ~pslverr;
  wire [7:0]  idx     = {{(10-AW){1'b0}}, paddr[AW-1:2]};
  wire        aligned = (paddr[1:0] == 2'b00);
  wire        wr_ie1  = wr_acc & (idx == `IVS_IDX_IE1);
  wire        wr_ie2  = wr_acc & (idx == `IVS_IDX_IE2);
  wire        wr_irq_flag_one = wr_acc & (idx == `IVS_IDX_IRQ_FLAG_ONE);
  wire        wr_irq_flag_two = wr_acc & (idx == `IVS_IDX_IRQ_FLAG_TWO);
  wire        wr_me2  = wr_acc & (idx == `IVS_IDX_ME2);
  wire        wr_pwr  = wr_acc & (idx == `IVS_IDX_PWR);
  wire        wr_vec  = wr_acc & (idx[7:4] == `IVS_IDX_VEC0 >> 4);
  wire        nmi_evt = ~pin_is_reset & pin_s3_q & ~pin_s2_q;
  wire        pin_rst = pin_is_reset & ~pin_s2_q;
  wire        take    = state_q[1] & irq_ack & irq_req;
  wire        boot    = state_q[0];
  wire [3:0]  rd_idx  = boot ? `IVS_PRI_RESET : pri_q;

  // Pin input passes two flops before the edge detector sees it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_s3_q <= 1'b1;
    end else begin
      pin_s1_q <= rst_nmi_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // enable bits clear on power-up clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie1_q               <= `IVS_RST_IE1;
      ie2_q               <= `IVS_RST_IE2;
      async_rx_module_en  <= 1'b0;
      async_tx_module_en  <= 1'b0;
      sync_mode_module_en <= 1'b0;
      mode_q              <= `IVS_MODE_RUN;
      dco_used_q          <= 1'b0;
    end else begin
      // only the four documented enable bits exist
      if (wr_ie1) begin
        ie1_q <= {pwdata[`IVS_BIT_FLASH], pwdata[`IVS_BIT_NMI],
                  pwdata[`IVS_BIT_OSC], pwdata[`IVS_BIT_WDOG]};
      end
      if (wr_ie2) begin
        ie2_q <= {pwdata[`IVS_BIT_STX], pwdata[`IVS_BIT_SRX]};
      end
      if (wr_me2) begin
        async_rx_module_en  <= pwdata[`IVS_BIT_ME_RX];
        async_tx_module_en  <= pwdata[`IVS_BIT_ME_TX];
        sync_mode_module_en <= pwdata[`IVS_BIT_ME_SYNC];
      end
      if (wr_pwr) begin
        mode_q     <= pwdata[2:0];
        dco_used_q <= pwdata[3];
      end
    end
  end

  // only a supply power-up resets the watchdog flag asynchronously
  always @(posedge pclk or negedge vcc_por_n) begin
    if (!vcc_por_n) begin
      wdog_flag_q <= 1'b0;
    // set on overflow or key violation, set wins over clear
    end else if (wdog_overflow | security_key_violation) begin
      wdog_flag_q <= 1'b1;
    // pin held in reset mode clears it
    end else if (pin_rst) begin
      wdog_flag_q <= 1'b0;
    end else if (wr_irq_flag_one) begin
      wdog_flag_q <= pwdata[`IVS_BIT_WDOG];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_flag_q <= 1'b0;
      nmi_flag_q <= 1'b0;
      stx_flag_q <= `IVS_RST_STX;
      srx_flag_q <= `IVS_RST_SRX;
    end else begin
      // fault and pin events set the flags
      if (osc_fault_det) begin
        osc_flag_q <= 1'b1;
      end else if (wr_irq_flag_one) begin
        osc_flag_q <= pwdata[`IVS_BIT_OSC];
      end
      if (nmi_evt) begin
        nmi_flag_q <= 1'b1;
      end else if (wr_irq_flag_one) begin
        nmi_flag_q <= pwdata[`IVS_BIT_NMI];
      end
      if (serial_tx_set) begin
        stx_flag_q <= 1'b1;
      end else if (serial_tx_clr) begin
        stx_flag_q <= 1'b0;
      end else if (wr_irq_flag_two) begin
        stx_flag_q <= pwdata[`IVS_BIT_STX];
      end
      if (serial_rx_set) begin
        srx_flag_q <= 1'b1;
      end else if (serial_rx_clr) begin
        srx_flag_q <= 1'b0;
      end else if (wr_irq_flag_two) begin
        srx_flag_q <= pwdata[`IVS_BIT_SRX];
      end
    end
  end

  // Request vector, one bit per priority slot
  always @* begin
    pend = 16'h0000;
    // global enable does not gate this slot
    pend[`IVS_PRI_NMI] = (nmi_flag_q & ie1_q[2]) | (osc_flag_q & ie1_q[1]) |
                         (flash_violation_flag & ie1_q[3]);
    // watchdog enable only counts in interval mode
    pend[`IVS_PRI_WDOG] = gie & wdog_flag_q & ie1_q[0] & wdog_interval_mode;
    pend[`IVS_PRI_CMP0] = gie & timer_cmp0_flag;
    pend[`IVS_PRI_TMR] = gie & timer_other_flags;
    pend[`IVS_PRI_SRX] = gie & srx_flag_q & ie2_q[0];
    pend[`IVS_PRI_STX] = gie & stx_flag_q & ie2_q[1];
    pend[`IVS_PRI_CONV] = gie & converter_done_flag;
    pend[`IVS_PRI_P2] = gie & (|port2_pin_flags);
    pend[`IVS_PRI_P1] = gie & (|port1_pin_flags);
  end

  // highest set slot wins; others stay pending
  always @* begin
    top_pri  = 4'h0;
    any_pend = 1'b0;
    for (k = 0; k < 16; k = k + 1) begin
      if (pend[k]) begin
        top_pri  = k[3:0];
        any_pend = 1'b1;
      end
    end
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_BOOT: state_d = ST_RUN;
      ST_RUN:  state_d = ST_RUN;
      default: state_d = ST_BOOT;
    endcase
  end

  // first cycle after reset fetches the top word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q          <= ST_BOOT;
      irq_req          <= 1'b0;
      irq_vec_addr     <= `IVS_TABLE_BASE;
      pri_q            <= 4'h0;
      handler_valid    <= 1'b0;
      handler_is_reset <= 1'b0;
      awake_q          <= 1'b0;
    end else begin
      state_q          <= state_d;
      handler_valid    <= boot | take;
      handler_is_reset <= boot;
      // Request drops the cycle after a take so one ack fetches once
      irq_req <= state_q[1] & any_pend & ~take;
      if (~take) begin
        pri_q <= top_pri;
        // slot n sits n words above the table base
        irq_vec_addr <= `IVS_TABLE_BASE + {11'h000, top_pri, 1'b0};
      end
      // stay awake until the handler returns
      if (take) begin
        awake_q <= 1'b1;
      end else if (irq_return) begin
        awake_q <= 1'b0;
      end
    end
  end

  // handler word read from the table on boot or on a take
  ivs_vec_mem #(
    .DW (16),
    .AW (4)
  ) u_vec (
    .pclk      (pclk),
    .presetn   (presetn),
    .wr_en     (wr_vec),
    .wr_addr   (idx[3:0]),
    .wr_data   (pwdata[15:0]),
    .rd_en     (boot | take),
    .rd_addr   (rd_idx),
    .rd_data_q (handler_addr)
  );

  // a pending request or a service in progress forces run mode
  always @* begin
    eff_mode = mode_q;
    if (awake_q | any_pend) begin
      eff_mode = `IVS_MODE_RUN;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_en   <= 1'b1;
      mclk_en  <= 1'b1;
      peripheral_sub_clock_en <= 1'b1;
      aclk_en  <= 1'b1;
      bias_en  <= 1'b1;
      xtal_en  <= 1'b1;
    end else begin
      case (eff_mode)
        `IVS_MODE_L0: begin
          {cpu_en, mclk_en, peripheral_sub_clock_en} <= 3'b001;
          {aclk_en, bias_en, xtal_en} <= 3'b111;
        end
        `IVS_MODE_L1: begin
          {cpu_en, mclk_en, peripheral_sub_clock_en} <= 3'b001;
          {aclk_en, bias_en, xtal_en} <= {1'b1, dco_used_q, 1'b1};
        end
        `IVS_MODE_L2: begin
          {cpu_en, mclk_en, peripheral_sub_clock_en} <= 3'b000;
          {aclk_en, bias_en, xtal_en} <= 3'b111;
        end
        `IVS_MODE_L3: begin
          {cpu_en, mclk_en, peripheral_sub_clock_en} <= 3'b000;
          {aclk_en, bias_en, xtal_en} <= 3'b101;
        end
        `IVS_MODE_L4: begin
          {cpu_en, mclk_en, peripheral_sub_clock_en} <= 3'b000;
          {aclk_en, bias_en, xtal_en} <= 3'b000;
        end
        // run mode and unused codes run every clock
        default: begin
          {cpu_en, mclk_en, peripheral_sub_clock_en} <= 3'b111;
          {aclk_en, bias_en, xtal_en} <= 3'b111;
        end
      endcase
    end
  end

  always @* begin
    rd_val  = 32'h00000000;
    addr_ok = aligned;
    case (idx)
      `IVS_IDX_IE1: begin
        rd_val[`IVS_BIT_FLASH] = ie1_q[3];
        rd_val[`IVS_BIT_NMI]   = ie1_q[2];
        rd_val[`IVS_BIT_OSC]   = ie1_q[1];
        rd_val[`IVS_BIT_WDOG]  = ie1_q[0];
      end
      `IVS_IDX_IE2: begin
        rd_val[`IVS_BIT_STX] = ie2_q[1];
        rd_val[`IVS_BIT_SRX] = ie2_q[0];
      end
      `IVS_IDX_IRQ_FLAG_ONE: begin
        rd_val[`IVS_BIT_NMI]  = nmi_flag_q;
        rd_val[`IVS_BIT_OSC]  = osc_flag_q;
        rd_val[`IVS_BIT_WDOG] = wdog_flag_q;
      end
      `IVS_IDX_IRQ_FLAG_TWO: begin
        rd_val[`IVS_BIT_STX] = stx_flag_q;
        rd_val[`IVS_BIT_SRX] = srx_flag_q;
      end
      `IVS_IDX_ME2: begin
        rd_val[`IVS_BIT_ME_RX]   = async_rx_module_en;
        rd_val[`IVS_BIT_ME_TX]   = async_tx_module_en;
        rd_val[`IVS_BIT_ME_SYNC] = sync_mode_module_en;
      end
      `IVS_IDX_PWR: begin
        rd_val[3:0] = {dco_used_q, mode_q};
      end
      `IVS_IDX_STAT: begin
        rd_val[5:0] = {awake_q, any_pend, top_pri};
      end
      default: begin
        // Table words are write-only; reads return zero without error
        addr_ok = aligned & (idx[7:4] == `IVS_IDX_VEC0 >> 4);
      end
    endcase
  end

  // Answer is prepared in the setup cycle, so access never waits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~addr_ok;
      if (setup & ~pwrite & addr_ok) begin
        prdata <= rd_val;
      end else if (setup) begin
        prdata <= 32'h00000000;
      end
    end
  end
endmodule
`default_nettype wire

// ### verilog/ivs_map.vh
// Register map, field positions, reset values and vector constants
// What this block does
// - Reset address and all vectors sit in a word table at the memory top.
// - Each vector word holds a 16-bit handler address loaded into the PC.
// - Power-up, external or watchdog reset fetch the top word, priority 15.
// - Pin NMI, oscillator fault, flash violation share word 14, own flags.
// - Those three are gated by their own enables only, never the global one.
// - Timer compare-0 flag has its own maskable vector at priority 9.
// - Compare-1, compare-2 and overflow flags share vector priority 8.
// - Serial receive flag requests a maskable vector at priority 7.
// - Serial transmit flag requests a separate maskable vector, priority 6.
// - All eight port-2 flags share vector priority 3.
// - All eight port-1 flags share vector priority 2.
// - Unassigned register bits are absent; writes to them do nothing.
// - First enable byte: violation bit 5, pin bit 4, osc bit 1, watchdog 0.
// - Watchdog enable acts only in interval mode, ignored in reset mode.
// - Watchdog flag sets on counter overflow or security key violation.
// - Watchdog flag clears on supply power-up or pin reset in reset mode.
// - Oscillator flag sets on fault; pin flag sets on pin NMI event.
// - Serial transmit flag resets to one, receive flag resets to zero.
// - Second enable byte has separate serial receive and transmit enables.
// - Module enable byte: async receive, async transmit, one sync enable.
// - Bits resetting to zero are read/write and, except the watchdog flag, clear on power-up clear.
// - Sleep level 0 stops CPU and main clock; run mode runs every clock.
// - Level 1 as level 0, bias off when the oscillator is unused in run.
// - Level 2 stops CPU, main and sub clocks; bias on, aux clock runs.
// - Level 3 as level 2 with bias off; aux clock still runs.
// - Level 4 stops CPU, all clocks, bias and the crystal.
// - Enabled interrupts wake every sleep level; return resumes the level.
`ifndef IVS_MAP_VH
`define IVS_MAP_VH
`define IVS_IDX_IE1        8'h00
`define IVS_IDX_IE2        8'h01
`define IVS_IDX_IRQ_FLAG_ONE       8'h02
`define IVS_IDX_IRQ_FLAG_TWO       8'h03
`define IVS_IDX_ME2        8'h05
`define IVS_IDX_PWR        8'h06
`define IVS_IDX_STAT       8'h07
`define IVS_IDX_VEC0       8'h10
`define IVS_BIT_WDOG       0
`define IVS_BIT_OSC        1
`define IVS_BIT_NMI        4
`define IVS_BIT_FLASH      5
`define IVS_BIT_SRX        0
`define IVS_BIT_STX        1
`define IVS_BIT_ME_RX      0
`define IVS_BIT_ME_TX      1
`define IVS_BIT_ME_SYNC    2
`define IVS_RST_IE1        4'h0
`define IVS_RST_IE2        2'h0
`define IVS_RST_ME2        3'h0
`define IVS_RST_STX        1'b1
`define IVS_RST_SRX        1'b0
`define IVS_RST_VEC        16'hf000
`define IVS_TABLE_BASE     16'hffe0
`define IVS_PRI_RESET      4'hf
`define IVS_PRI_NMI        4'he
`define IVS_PRI_WDOG       4'ha
`define IVS_PRI_CMP0       4'h9
`define IVS_PRI_TMR        4'h8
`define IVS_PRI_SRX        4'h7
`define IVS_PRI_STX        4'h6
`define IVS_PRI_CONV       4'h5
`define IVS_PRI_P2         4'h3
`define IVS_PRI_P1         4'h2
`define IVS_MODE_RUN       3'h0
`define IVS_MODE_L0        3'h1
`define IVS_MODE_L1        3'h2
`define IVS_MODE_L2        3'h3
`define IVS_MODE_L3        3'h4
`define IVS_MODE_L4        3'h5
`endif

// ### verilog/ivs_vec_mem.v
// Vector word table with registered read port
`timescale 1ns/1ns
`default_nettype none
`include "ivs_map.vh"
module ivs_vec_mem #(
  parameter DW = 16,
  parameter AW = 4
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  input  wire          rd_en,
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data_q
);
  reg [DW-1:0] mem_q [0:(1<<AW)-1];
  integer i;

  // Reset contents give the boot fetch a defined handler before software
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < (1<<AW); i = i + 1) begin
        mem_q[i] <= `IVS_RST_VEC;
      end
    end else if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_q <= {DW{1'b0}};
    end else if (rd_en) begin
      rd_data_q <= mem_q[rd_addr];
    end
  end
endmodule
`default_nettype wire
